// *** rtl/osc_edge_detect.v ***
// rising-edge detector on the sampled sub-oscillator clock
`timescale 1ns/1ps
`default_nettype none

module osc_edge_detect (
    input  wire clk,
    input  wire resetn,
    input  wire oscIn,
    output wire oscRise
);
    reg oscPrev_q;

    // oscIn is taken as synchronous, so one stage is enough for the edge
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oscPrev_q <= 1'b0;
        end else begin
            oscPrev_q <= oscIn;
        end
    end

    assign oscRise = oscIn & ~oscPrev_q;
endmodule // osc_edge_detect

`default_nettype wire

// *** rtl/subclock_watchdog_nmi.v ***
// sub-clock watchdog with non-maskable interrupt and shared clock-output control
`timescale 1ns/1ps
`default_nettype none
`include "subclock_watchdog_regs.vh"

//
// Function
// - counter ticks on the low-speed oscillator; missed restart raises the NMI.
// - period option fixed at build: 32768, 65536, 131072 or 262144 cycles.
// - enable resets to one, so counting starts right after reset.
// - counting continues while the CPU is halted.
// - counter freezes while the chip sleeps.
// - actual timeout lies between three quarters and the full period.
// - timeout is an unmaskable level 4 interrupt with top priority.
// - exception vector for the watchdog interrupt is address 000004H.
// - enable bit 7 of the control register, read back as written.
// - writing one to bit 2 clears the upper two counter stages and restarts; zero does nothing.
// - restart bit is write-only and always reads zero.
module subclock_watchdog_nmi #(
    parameter [1:0] PERIOD_SEL = `WDOG_SEL_DEFAULT,
    parameter       DIV_WIDTH  = 18
) (
    input  wire                 clk,
    input  wire                 resetn,
    // avalon-mm slave
    input  wire [15:0]          avs_address,
    input  wire                 avs_read,
    input  wire                 avs_write,
    input  wire [31:0]          avs_writedata,
    input  wire [3:0]           avs_byteenable,
    output reg  [31:0]          avs_readdata,
    output wire                 avs_waitrequest,
    output reg  [1:0]           avs_response,
    // oscillator and cpu state
    input  wire                 lowSpeedOsc,
    input  wire                 cpuHalted,
    input  wire                 chipSleep,
    // cpu non-maskable interrupt
    output reg                  nmiRequest,
    output wire [2:0]           nmiLevel,
    output wire [23:0]          nmiVector,
    input  wire                 nmiAck,
    // forwarded to clock-output and tick timer
    output wire                 clkoutFreqSelHi,
    output wire                 clkoutFreqSelMid,
    output wire                 clkoutFreqSelLo,
    output wire                 clkoutOn,
    output reg                  tickTimerClear,
    output wire                 tickTimerRun,
    // software interrupt
    output wire                 irq
);
    // =====================================================
    // bus slave state
    localparam ST_IDLE = 1'b0;
    localparam ST_DONE = 1'b1;

    reg                   state_q;
    reg  [7:0]            ctrl_q;
    reg  [7:0]            ctrlWrite;
    reg  [`WDOG_EV_WIDTH-1:0] irqStat_q;
    reg  [`WDOG_EV_WIDTH-1:0] irqMask_q;
    reg  [`WDOG_EV_WIDTH-1:0] irqStat_d;
    reg                   restartPulse;
    wire                  oscRise;
    wire                  wdExpire;
    wire [DIV_WIDTH-1:0]  wdCount;
    wire                  wdRun;
    wire                  busReq;
    wire                  accept;

    function mapped;
        input [15:0] addr;
        begin
            mapped = (addr == `WDOG_CTRL_OFS) || (addr == `WDOG_IRQ_STAT_OFS) ||
                     (addr == `WDOG_IRQ_MASK_OFS) || (addr == `WDOG_COUNT_OFS);
        end
    endfunction

    // =====================================================
    // avalon handshake: one wait cycle, answer in the second
    assign busReq          = avs_read | avs_write;
    assign accept          = busReq & (state_q == ST_DONE);
    assign avs_waitrequest = busReq & (state_q == ST_IDLE);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (busReq) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // control register writes
    always @* begin
        ctrlWrite = ctrl_q;
        restartPulse = 1'b0;
        if (accept && avs_write && avs_address == `WDOG_CTRL_OFS && avs_byteenable[0]) begin
            // strobe bits are not stored, so a read sees zero there
            ctrlWrite = avs_writedata[7:0] & `WDOG_CTRL_RW_MASK;
            restartPulse = avs_writedata[`WDOG_RESTART_BIT];
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q         <= `WDOG_CTRL_RESET;
            tickTimerClear <= 1'b0;
        end else begin
            ctrl_q         <= ctrlWrite;
            tickTimerClear <= accept & avs_write & (avs_address == `WDOG_CTRL_OFS) &
                              avs_byteenable[0] & avs_writedata[`WDOG_TICK_CLR_BIT];
        end
    end

    assign clkoutFreqSelHi  = ctrl_q[`WDOG_FSEL_HI_BIT];
    assign clkoutFreqSelMid = ctrl_q[`WDOG_FSEL_MID_BIT];
    assign clkoutFreqSelLo  = ctrl_q[`WDOG_FSEL_LO_BIT];
    assign clkoutOn         = ctrl_q[`WDOG_CLKOUT_ON_BIT];
    assign tickTimerRun     = ctrl_q[`WDOG_TICK_RUN_BIT];

    // =====================================================
    // watchdog core
    osc_edge_detect u_edge (
        .clk     (clk),
        .resetn  (resetn),
        .oscIn   (lowSpeedOsc),
        .oscRise (oscRise)
    );

    // halt does not stop it, sleep does; disable also blocks the interrupt
    assign wdRun = ctrl_q[`WDOG_EN_BIT] & ~chipSleep;

    wdog_divider #(
        .WIDTH (DIV_WIDTH)
    ) u_div (
        .clk       (clk),
        .resetn    (resetn),
        .tick      (oscRise),
        .run       (wdRun),
        .restart   (restartPulse),
        .periodSel (PERIOD_SEL),
        .count     (wdCount),
        .expire    (wdExpire)
    );

    // nmi stays asserted until the cpu takes it; a new timeout wins over the ack
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nmiRequest <= 1'b0;
        end else if (wdExpire) begin
            nmiRequest <= 1'b1;
        end else if (nmiAck) begin
            nmiRequest <= 1'b0;
        end
    end

    assign nmiLevel  = `WDOG_NMI_LEVEL;
    assign nmiVector = `WDOG_NMI_VECTOR;

    // =====================================================
    // sticky status for software, cleared by reading; events win over the clear
    always @* begin
        irqStat_d = irqStat_q;
        if (accept && avs_read && avs_address == `WDOG_IRQ_STAT_OFS) begin
            irqStat_d = {`WDOG_EV_WIDTH{1'b0}};
        end
        if (wdExpire) begin
            irqStat_d[`WDOG_EV_TIMEOUT_BIT] = 1'b1;
        end
        if (restartPulse) begin
            irqStat_d[`WDOG_EV_RESTART_BIT] = 1'b1;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqStat_q <= {`WDOG_EV_WIDTH{1'b0}};
            irqMask_q <= {`WDOG_EV_WIDTH{1'b0}};
        end else begin
            irqStat_q <= irqStat_d;
            if (accept && avs_write && avs_address == `WDOG_IRQ_MASK_OFS && avs_byteenable[0]) begin
                irqMask_q <= avs_writedata[`WDOG_EV_WIDTH-1:0];
            end
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    // =====================================================
    // read data and response
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (busReq && state_q == ST_IDLE) begin
            avs_response <= mapped(avs_address) ? 2'b00 : 2'b11;
            case (avs_address)
                `WDOG_CTRL_OFS:     avs_readdata <= {24'h00_0000, ctrl_q};
                `WDOG_IRQ_STAT_OFS: avs_readdata <= {30'h0000_0000, irqStat_q};
                `WDOG_IRQ_MASK_OFS: avs_readdata <= {30'h0000_0000, irqMask_q};
                `WDOG_COUNT_OFS:    avs_readdata <= {14'h0000, wdCount};
                default:            avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // subclock_watchdog_nmi

`default_nettype wire

// *** rtl/subclock_watchdog_regs.vh ***
// register offsets, bit positions, reset values and timing counts of the sub-clock watchdog
`ifndef SUBCLOCK_WATCHDOG_REGS_VH
`define SUBCLOCK_WATCHDOG_REGS_VH

// =====================================================
// register map (byte addresses, word aligned)
`define WDOG_CTRL_OFS        16'hff40
`define WDOG_IRQ_STAT_OFS    16'hff44
`define WDOG_IRQ_MASK_OFS    16'hff48
`define WDOG_COUNT_OFS       16'hff4c

// =====================================================
// control register fields
`define WDOG_EN_BIT          7
`define WDOG_FSEL_HI_BIT     6
`define WDOG_FSEL_MID_BIT    5
`define WDOG_FSEL_LO_BIT     4
`define WDOG_CLKOUT_ON_BIT   3
`define WDOG_RESTART_BIT     2
`define WDOG_TICK_CLR_BIT    1
`define WDOG_TICK_RUN_BIT    0
`define WDOG_CTRL_RESET      8'h80
`define WDOG_CTRL_RW_MASK    8'hf9

// =====================================================
// interrupt status bits
`define WDOG_EV_TIMEOUT_BIT  0
`define WDOG_EV_RESTART_BIT  1
`define WDOG_EV_WIDTH        2

// =====================================================
// timing and nmi: period options as sub-oscillator cycles, default select, nmi level and vector
`define WDOG_PERIOD_32K      32768
`define WDOG_PERIOD_64K      65536
`define WDOG_PERIOD_128K     131072
`define WDOG_PERIOD_256K     262144
`define WDOG_SEL_DEFAULT     2
`define WDOG_NMI_LEVEL       3'h4
`define WDOG_NMI_VECTOR      24'h00_0004

`endif

// *** rtl/wdog_divider.v ***
// watchdog divider chain counting sub-oscillator ticks
`timescale 1ns/1ps
`default_nettype none

module wdog_divider #(
    parameter WIDTH = 18
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             tick,
    input  wire             run,
    input  wire             restart,
    input  wire [1:0]       periodSel,
    output wire [WIDTH-1:0] count,
    output wire             expire
);
    reg  [WIDTH-1:0] count_q;
    reg  [WIDTH-1:0] count_d;
    reg  [WIDTH-1:0] keepMask;
    reg  [WIDTH-1:0] termMask;

    // restart clears only the upper two stages of the selected period
    always @* begin
        case (periodSel)
            2'd0: begin
                keepMask = {{(WIDTH-13){1'b0}}, 13'h1fff};
                termMask = {{(WIDTH-15){1'b0}}, 15'h7fff};
            end
            2'd1: begin
                keepMask = {{(WIDTH-14){1'b0}}, 14'h3fff};
                termMask = {{(WIDTH-16){1'b0}}, 16'hffff};
            end
            2'd2: begin
                keepMask = {{(WIDTH-15){1'b0}}, 15'h7fff};
                termMask = {{(WIDTH-17){1'b0}}, 17'h1_ffff};
            end
            default: begin
                keepMask = {{(WIDTH-16){1'b0}}, 16'hffff};
                termMask = {WIDTH{1'b1}};
            end
        endcase
    end

    always @* begin
        count_d = count_q;
        if (restart) begin
            count_d = count_q & keepMask;
        end else if (run && tick) begin
            count_d = (count_q == termMask) ? {WIDTH{1'b0}} : count_q + 1'b1;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    assign count  = count_q;
    assign expire = run & tick & ~restart & (count_q == termMask);
endmodule // wdog_divider

`default_nettype wire

// *** testbench/cpu_nmi_model.sv ***
// cpu-side model that takes and acknowledges the watchdog nmi
`timescale 1ns/1ps
`default_nettype none
// ========
// model
module cpu_nmi_model #(parameter int GUARD = 132) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic        nmiRequest,
    input  wire logic [2:0]  nmiLevel,
    input  wire logic [23:0] nmiVector,
    output var logic         nmiAck,
    output var logic [2:0]   tkLevel,
    output var logic [23:0]  tkVector,
    output var logic [7:0]   nmiCnt,
    output var logic         sleepHold
);
    logic [7:0] waitQ;
    int         guardQ;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nmiAck <= 1'b0;
            waitQ <= 8'h00;
            guardQ <= 0;
            nmiCnt <= 8'h00;
            tkLevel <= 3'h0;
            tkVector <= 24'h00_0000;
        end else begin
            nmiAck <= 1'b0;
            if (guardQ != 0) guardQ <= guardQ - 1;
            // no mask exists on this path, so a request is always taken
            if (nmiRequest && !nmiAck) begin
                if (waitQ == (slow ? 8'h14 : 8'h01)) begin
                    nmiAck <= 1'b1;
                    tkLevel <= nmiLevel;
                    tkVector <= nmiVector;
                    nmiCnt <= nmiCnt + 8'h01;
                    guardQ <= GUARD;
                    waitQ <= 8'h00;
                end else waitQ <= waitQ + 8'h01;
            end
        end
    end
    assign sleepHold = guardQ != 0;
endmodule // cpu_nmi_model
`default_nettype wire

// *** testbench/subclock_watchdog_nmi_assertions.sv ***
// port assertions for the sub-clock watchdog
`timescale 1ns/1ps
`default_nettype none
// ========
// checker
module wdog_chk (
    input wire        clk,
    input wire        resetn,
    input wire [15:0] avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [1:0]  avs_response,
    input wire        chipSleep,
    input wire        nmiRequest,
    input wire [2:0]  nmiLevel,
    input wire [23:0] nmiVector,
    input wire        nmiAck,
    input wire        tickTimerClear,
    input wire        clkoutOn,
    input wire        tickTimerRun
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire req    = avs_read | avs_write;
    wire done   = req & ~avs_waitrequest;
    wire ctrlWr = done & avs_write & (avs_address == 16'hff40);
    wire mapped = (avs_address[15:4] == 12'hff4) & (avs_address[1:0] == 2'h0);
    property p_wait; $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("wait cycle wrong");
    property p_resp; done |-> avs_response == (mapped ? 2'h0 : 2'h3); endproperty
    a_resp: assert property (p_resp) else $error("bad response");
    property p_ctrl_rd;
        done && avs_read && avs_address == 16'hff40 |->
            avs_readdata[31:8] == 24'h00_0000 && avs_readdata[2:1] == 2'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("strobe bits read");
    property p_nmi_const; nmiLevel == 3'h4 && nmiVector == 24'h00_0004; endproperty
    a_nmi_const: assert property (p_nmi_const) else $error("nmi level");
    property p_nmi_hold; nmiRequest && !nmiAck |=> nmiRequest; endproperty
    a_nmi_hold: assert property (p_nmi_hold) else $error("nmi dropped");
    // two cycles of margin cover the nmiRequest register stage, since chipSleep gates the expire combinationally
    property p_sleep;
        chipSleep && $past(chipSleep) && $past(chipSleep, 2) |-> !$rose(nmiRequest);
    endproperty
    a_sleep: assert property (p_sleep) else $error("nmi in sleep");
    property p_tclr;
        $rose(tickTimerClear) |->
            ($past(ctrlWr && avs_writedata[1]) || $past(ctrlWr && avs_writedata[1], 2))
            ##1 !tickTimerClear;
    endproperty
    a_tclr: assert property (p_tclr) else $error("tick clear pulse");
    property p_fwd;
        !$stable({clkoutOn, tickTimerRun}) |-> $past(ctrlWr) || $past(ctrlWr, 2);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded bit moved");
    c_nmi: cover property ($rose(nmiRequest));
    c_unmap: cover property (done && !mapped);
    c_tclr: cover property ($rose(tickTimerClear));
endmodule // wdog_chk

bind subclock_watchdog_nmi wdog_chk i_wdog_chk (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .chipSleep(chipSleep), .nmiRequest(nmiRequest), .nmiLevel(nmiLevel),
    .nmiVector(nmiVector), .nmiAck(nmiAck), .tickTimerClear(tickTimerClear),
    .clkoutOn(clkoutOn), .tickTimerRun(tickTimerRun));
`default_nettype wire

// *** testbench/subclock_watchdog_nmi_tb.sv ***
// self-checking bench for the sub-clock watchdog
`timescale 1ns/1ps
`default_nettype none
// ========
// bench
module subclock_watchdog_nmi_tb;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic        lowSpeedOsc = 1'b0;
    logic        cpuHalted = 1'b0;
    logic        chipSleep = 1'b0;
    logic [31:0] avs_readdata, rd, c0, c1, seed = 32'h0000_8ed4;
    logic        avs_waitrequest, nmiRequest, nmiAck, fHi, fMid, fLo, fOn, tClr, tRun, irq;
    logic [1:0]  avs_response, lastResp;
    logic [2:0]  nmiLevel, tkLevel;
    logic [23:0] nmiVector, tkVector;
    logic [7:0]  nmiCnt, v;
    int          cyc = 0, error_cnt = 0, check_count = 0, d;
    subclock_watchdog_nmi #(.PERIOD_SEL(2'h0)) i_subclock_watchdog_nmi (
        .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .lowSpeedOsc(lowSpeedOsc), .cpuHalted(cpuHalted),
        .chipSleep(chipSleep), .nmiRequest(nmiRequest), .nmiLevel(nmiLevel),
        .nmiVector(nmiVector), .nmiAck(nmiAck), .clkoutFreqSelHi(fHi),
        .clkoutFreqSelMid(fMid), .clkoutFreqSelLo(fLo), .clkoutOn(fOn),
        .tickTimerClear(tClr), .tickTimerRun(tRun), .irq(irq));
    cpu_nmi_model i_cpu_nmi_model (
        .clk(clk), .resetn(resetn), .slow(1'b1), .nmiRequest(nmiRequest),
        .nmiLevel(nmiLevel), .nmiVector(nmiVector), .nmiAck(nmiAck), .tkLevel(tkLevel),
        .tkVector(tkVector), .nmiCnt(nmiCnt), .sleepHold());
    always #4 clk = ~clk;
    // fastest legal tick keeps the shortest period near 65k clocks
    always @(posedge clk) begin
        lowSpeedOsc <= ~lowSpeedOsc;
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            error_cnt++;
            finish_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] expCtrl(input logic [7:0] w);
        expCtrl = w & 8'hf9;
    endfunction
    task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpr(input logic ok);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, ok, 1'b1);
        end
    endtask
    // waitrequest is sampled at rising edges; returns at a falling edge so checks see settled values
    task automatic bus(input logic rdn, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= rdn;
        avs_write <= !rdn;
        avs_writedata <= wd;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) error_cnt++;
        q = avs_readdata;
        lastResp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge clk);
    endtask
    task automatic finish_test;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        bus(1'b1, 16'hff40, 32'h0, rd);
        cmpv(rd, 32'h0000_0080);
        bus(1'b1, 16'hff50, 32'h0, rd);
        cmpv({rd[29:0], lastResp}, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cpuHalted <= (i == 1);
            chipSleep <= (i == 2);
            if (i == 3) bus(1'b0, 16'hff40, 32'h0, rd);
            repeat (4) @(posedge clk);
            bus(1'b1, 16'hff4c, 32'h0, c0);
            repeat (40) @(posedge clk);
            bus(1'b1, 16'hff4c, 32'h0, c1);
            d = c1 - c0;
            cmpr(i >= 2 ? d == 0 : d >= 19 && d <= 23);
        end
        @(posedge clk);
        chipSleep <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'hff : seed[7:0];
            bus(1'b0, 16'hff40, {24'h0, v}, rd);
            bus(1'b1, 16'hff40, 32'h0, rd);
            cmpv(rd, {24'h0, expCtrl(v)});
            cmpv({fHi, fMid, fLo, fOn, tRun}, {v[6:3], v[0]});
        end
        bus(1'b0, 16'hff48, 32'h2, rd);
        // drop restart events left by the random writes so the next irq check means something
        bus(1'b1, 16'hff44, 32'h0, rd);
        cmpr(irq === 1'b0);
        bus(1'b0, 16'hff40, 32'h80, rd);
        repeat (20000) @(posedge clk);
        bus(1'b1, 16'hff4c, 32'h0, c0);
        bus(1'b0, 16'hff40, 32'h80, rd);
        bus(1'b1, 16'hff4c, 32'h0, c1);
        cmpr(c1 > c0);
        bus(1'b0, 16'hff40, 32'h84, rd);
        cmpr(irq === 1'b1);
        bus(1'b1, 16'hff44, 32'h0, rd);
        cmpv(rd, 32'h0000_0002);
        cmpr(irq === 1'b0);
        bus(1'b0, 16'hff48, 32'h1, rd);
        bus(1'b0, 16'hff40, 32'h84, rd);
        cmpr(irq === 1'b0);
        bus(1'b1, 16'hff4c, 32'h0, c1);
        cmpr(c1[31:13] == 0 && c1[12:0] >= c0[12:0]);
        d = 0;
        while (nmiRequest !== 1'b1 && d < 70000) begin
            @(negedge clk);
            d++;
        end
        d = d / 2;
        cmpr(d + c1 >= 32765 && d + c1 <= 32771);
        cmpr(d >= 24570 && d <= 32768);
        d = 0;
        while (nmiCnt == 8'h00 && d < 100) begin
            @(negedge clk);
            d++;
        end
        cmpv({5'h0, tkLevel, tkVector}, 32'h0400_0004);
        cmpr(irq === 1'b1);
        bus(1'b1, 16'hff44, 32'h0, rd);
        cmpv(rd, 32'h0000_0003);
        finish_test();
    end
endmodule // subclock_watchdog_nmi_tb
`default_nettype wire
